// >>> design/dcef_flags.sv
// event flag register of one dma channel
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module dcef_flags #(
  parameter int unsigned SIZE_W = 16,
  parameter int unsigned IRQ_W  = 8
) (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [dcef_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [31:0]                rdata_o,
  input  wire logic [SIZE_W-1:0]          dest_pointer_i,
  input  wire logic [SIZE_W-1:0]          dest_size_i,
  input  wire logic                       block_done_i,
  input  wire logic                       pattern_match_i,
  input  wire logic                       cell_done_i,
  input  wire logic                       irq_valid_i,
  input  wire logic [IRQ_W-1:0]           irq_num_i,
  input  wire logic                       src_addr_bad_i,
  input  wire logic                       dst_addr_bad_i,
  output logic                            transfer_abort_o,
  output logic      [IRQ_W-1:0]           abort_request_select_o
);
  logic [dcef_pkg::NUM_FLAGS-1:0] flags, next_flags;
  logic [IRQ_W-1:0]               abort_request_select, next_abort_request_select;
  logic                           abort_en, next_abort_en;
  logic                           abort_pulse, next_abort_pulse;
  logic [31:0]                    rdata, next_rdata;
  logic [dcef_pkg::NUM_FLAGS-1:0] ev;

  always_comb begin
    ev = '0;
    ev[dcef_pkg::DONE_BIT]  = (dest_size_i != '0) && (dest_pointer_i == dest_size_i);
    ev[dcef_pkg::HALF_BIT]  = (dest_size_i != '0) && (dest_pointer_i == (dest_size_i >> 1));
    ev[dcef_pkg::BLOCK_BIT] = block_done_i | pattern_match_i;
    ev[dcef_pkg::CELL_BIT]  = cell_done_i;
    ev[dcef_pkg::ABORT_BIT] = abort_en && irq_valid_i && (irq_num_i == abort_request_select);
    ev[dcef_pkg::ERR_BIT]   = src_addr_bad_i | dst_addr_bad_i;
  end

  always_comb begin
    next_flags                = flags;
    next_abort_request_select = abort_request_select;
    next_abort_en             = abort_en;
    next_rdata                = 32'h0000_0000;
    if (wr_i && addr_i == dcef_pkg::INT_CTRL_OFF) begin
      next_flags = flags & ~wdata_i[dcef_pkg::NUM_FLAGS-1:0];
    end
    if (wr_i && addr_i == dcef_pkg::CONFIG_OFF) begin
      next_abort_request_select = wdata_i[IRQ_W-1:0];
      next_abort_en             = wdata_i[dcef_pkg::ABORT_EN_BIT];
    end
    // set beats clear in the same cycle
    next_flags       = next_flags | ev;
    next_abort_pulse = ev[dcef_pkg::ABORT_BIT];
    if (rd_i) begin
      unique case (addr_i)
        dcef_pkg::INT_CTRL_OFF: next_rdata = {{(32-dcef_pkg::NUM_FLAGS){1'h0}}, flags};
        dcef_pkg::CONFIG_OFF:   next_rdata = {abort_en, {(31-IRQ_W){1'h0}}, abort_request_select};
        dcef_pkg::STATUS_OFF:   next_rdata = {{(32-SIZE_W){1'b0}}, dest_pointer_i};
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags                <= dcef_pkg::FLAGS_RESET;
      abort_request_select <= dcef_pkg::ABORT_SEL_RESET[IRQ_W-1:0];
      abort_en             <= dcef_pkg::ABORT_EN_RESET;
      abort_pulse          <= 1'h0;
      rdata                <= dcef_pkg::RDATA_RESET;
    end else begin
      flags                <= next_flags;
      abort_request_select <= next_abort_request_select;
      abort_en             <= next_abort_en;
      abort_pulse          <= next_abort_pulse;
      rdata                <= next_rdata;
    end
  end

  assign rdata_o                = rdata;
  assign transfer_abort_o       = abort_pulse;
  assign abort_request_select_o = abort_request_select;

  // pointer conditions taken from the ports, independent of ev
  sequence s_dest_end;
    dest_size_i != '0 && dest_pointer_i == dest_size_i;
  endsequence

  sequence s_dest_mid;
    dest_size_i != '0 && dest_pointer_i == (dest_size_i >> 1);
  endsequence

  property p_done_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_dest_end |=> flags[dcef_pkg::DONE_BIT];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag missed");

  property p_half_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_dest_mid |=> flags[dcef_pkg::HALF_BIT];
  endproperty
  a_half_set: assert property (p_half_set) else $error("half flag missed");

  property p_block_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      (block_done_i || pattern_match_i) |=> flags[dcef_pkg::BLOCK_BIT];
  endproperty
  a_block_set: assert property (p_block_set) else $error("block flag missed");

  property p_cell_set;
    @(posedge clk_i) disable iff (sys_rst_i) cell_done_i |=> flags[dcef_pkg::CELL_BIT];
  endproperty
  a_cell_set: assert property (p_cell_set) else $error("cell flag missed");

  sequence s_abort_hit;
    abort_en && irq_valid_i && irq_num_i == abort_request_select;
  endsequence
  property p_abort;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_abort_hit |=> (transfer_abort_o && flags[dcef_pkg::ABORT_BIT]);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not raised");

  property p_err_set;
    @(posedge clk_i) disable iff (sys_rst_i)
      (src_addr_bad_i || dst_addr_bad_i) |=> flags[dcef_pkg::ERR_BIT];
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag missed");

  property p_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
      !(wr_i && addr_i == dcef_pkg::INT_CTRL_OFF) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_no_spurious;
    @(posedge clk_i) disable iff (sys_rst_i)
      (ev == '0 && !$past(sys_rst_i)) |=> ((flags & ~$past(flags)) == '0);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without event");

  sequence s_flag_clear;
    wr_i && addr_i == dcef_pkg::INT_CTRL_OFF;
  endsequence

  sequence s_config_write;
    wr_i && addr_i == dcef_pkg::CONFIG_OFF;
  endsequence

  // a cleared bit may only come back through its own event
  property p_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_flag_clear |=> ((flags & $past(wdata_i[dcef_pkg::NUM_FLAGS-1:0]) & ~$past(ev)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by write");

  // software must not lose an event by clearing at the wrong moment
  property p_set_wins;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_flag_clear ##0 (block_done_i || pattern_match_i) |=> flags[dcef_pkg::BLOCK_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

  property p_config_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_config_write |=> (abort_request_select_o == $past(wdata_i[IRQ_W-1:0])
                          && abort_en == $past(wdata_i[dcef_pkg::ABORT_EN_BIT]));
  endproperty
  a_config_write: assert property (p_config_write) else $error("config write lost");

  property p_abort_miss;
    @(posedge clk_i) disable iff (sys_rst_i)
      !(abort_en && irq_valid_i && irq_num_i == abort_request_select) |=> !transfer_abort_o;
  endproperty
  a_abort_miss: assert property (p_abort_miss) else $error("abort without match");

  property p_abort_rose;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(flags[dcef_pkg::ABORT_BIT]) |-> transfer_abort_o;
  endproperty
  a_abort_rose: assert property (p_abort_rose) else $error("abort flag without pulse");

  // read data stands for one cycle only, zero otherwise
  property p_rdata_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
      !rd_i |=> rdata_o == dcef_pkg::RDATA_RESET;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

  property p_flag_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == dcef_pkg::INT_CTRL_OFF)
        |=> rdata_o == {{(32-dcef_pkg::NUM_FLAGS){1'h0}}, $past(flags)};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

  property p_config_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == dcef_pkg::CONFIG_OFF)
        |=> rdata_o == {$past(abort_en), {(31-IRQ_W){1'h0}}, $past(abort_request_select)};
  endproperty
  a_config_read: assert property (p_config_read) else $error("config read wrong");

  property p_status_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i == dcef_pkg::STATUS_OFF)
        |=> rdata_o[SIZE_W-1:0] == $past(dest_pointer_i);
  endproperty
  a_status_read: assert property (p_status_read) else $error("pointer read wrong");

  property p_unmapped_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      (rd_i && addr_i != dcef_pkg::INT_CTRL_OFF && addr_i != dcef_pkg::CONFIG_OFF
       && addr_i != dcef_pkg::STATUS_OFF) |=> rdata_o == dcef_pkg::RDATA_RESET;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // no disable here: it watches the reset itself
  property p_reset_state;
    @(posedge clk_i)
      sys_rst_i |=> (flags == dcef_pkg::FLAGS_RESET && !transfer_abort_o
                     && rdata_o == dcef_pkg::RDATA_RESET);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state not reset");
endmodule

// >>> design/dcef_pkg.sv
// constants for the dma channel event flag block
// Behaviour
// - dest_done_flag sets when dest_pointer equals dest_size; else reads 0. Here it stays set until a write to INT_CTRL_OFF clears it.
// - dest_half_flag sets when dest_pointer equals half of dest_size; else 0. Here it stays set until a write to INT_CTRL_OFF clears it.
// - block_complete_flag sets when larger size transferred or pattern match occurs.
// - cell_complete_flag sets each time cell_size bytes have been transferred.
// - abort request matching abort_request_select aborts transfer, sets transfer_abort_flag. Here only while abort_en (ABORT_EN_BIT of CONFIG_OFF) is set.
// - address_error_flag sets when source or destination address is invalid.
package dcef_pkg;
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  INT_CTRL_OFF    = 4'h0;
  localparam logic [3:0]  CONFIG_OFF      = 4'h4;
  localparam logic [3:0]  STATUS_OFF      = 4'h8;
  localparam int unsigned ERR_BIT         = 0;
  localparam int unsigned ABORT_BIT       = 1;
  localparam int unsigned CELL_BIT        = 2;
  localparam int unsigned BLOCK_BIT       = 3;
  localparam int unsigned HALF_BIT        = 4;
  localparam int unsigned DONE_BIT        = 5;
  localparam int unsigned NUM_FLAGS       = 6;
  localparam logic [5:0]  FLAGS_RESET     = 6'h00;
  localparam logic [7:0]  ABORT_SEL_RESET = 8'h00;
  localparam int unsigned ABORT_EN_BIT    = 31;
  localparam logic        ABORT_EN_RESET  = 1'h0;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
endpackage

// >>> test/dcef_flags_bench.sv
// self-checking bench for the dma channel event flag block
`timescale 1ns/1ps
module dcef_flags_bench;
  logic        clk_i, sys_rst_i, wr_i, rd_i, transfer_abort_o;
  logic        block_done_i, pattern_match_i, cell_done_i, irq_valid_i;
  logic        src_addr_bad_i, dst_addr_bad_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [15:0] dest_pointer_i, dest_size_i;
  logic [7:0]  irq_num_i, abort_request_select_o;
  int          miscompares = 0;
  int          n_checks = 0;
  int          bit_of[8] = '{0, 1, 2, 3, 4, 5, 0, 3};
  dcef_flags dcef_flags_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .dest_pointer_i(dest_pointer_i), .dest_size_i(dest_size_i), .block_done_i(block_done_i),
    .pattern_match_i(pattern_match_i), .cell_done_i(cell_done_i), .irq_valid_i(irq_valid_i),
    .irq_num_i(irq_num_i), .src_addr_bad_i(src_addr_bad_i), .dst_addr_bad_i(dst_addr_bad_i),
    .transfer_abort_o(transfer_abort_o), .abort_request_select_o(abort_request_select_o));
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask
  // one event for one cycle, then sticky check and clear
  task automatic hit(input int b);
    @(posedge clk_i);
    case (b)
      0: src_addr_bad_i <= 1'h1;
      1: irq_valid_i <= 1'h1;
      2: cell_done_i <= 1'h1;
      3: block_done_i <= 1'h1;
      4: dest_pointer_i <= 16'h4;
      5: dest_pointer_i <= 16'h8;
      6: dst_addr_bad_i <= 1'h1;
      default: pattern_match_i <= 1'h1;
    endcase
    @(posedge clk_i);
    {dst_addr_bad_i, src_addr_bad_i, cell_done_i, block_done_i} <= 4'h0;
    {irq_valid_i, pattern_match_i} <= 2'h0;
    dest_pointer_i <= 16'h1;
    #1 if (b == 1) chk(transfer_abort_o, 1'h1, "abort pulse");
    repeat (3) @(posedge clk_i);
    rd(dcef_pkg::INT_CTRL_OFF);
    chk(d, 32'h1 << bit_of[b], "flags set");
    wr(dcef_pkg::INT_CTRL_OFF, 32'h1 << bit_of[b]);
    rd(dcef_pkg::INT_CTRL_OFF);
    chk(d, 32'h0, "flags cleared");
    $display("test event %0d done", b);
  endtask
  // clear write and new event on one edge: the event must survive
  task automatic set_wins();
    @(posedge clk_i);
    addr_i <= dcef_pkg::INT_CTRL_OFF;
    wdata_i <= 32'h0000_0008;
    wr_i <= 1'h1;
    block_done_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
    block_done_i <= 1'h0;
    rd(dcef_pkg::INT_CTRL_OFF);
    chk(d, 32'h0000_0008, "set beats clear");
    wr(dcef_pkg::INT_CTRL_OFF, 32'h0000_0008);
    $display("test set wins done");
  endtask
  task automatic abort_miss();
    @(posedge clk_i);
    irq_num_i <= 8'h6;
    irq_valid_i <= 1'h1;
    @(posedge clk_i);
    irq_valid_i <= 1'h0;
    irq_num_i <= 8'h5;
    #1 chk(transfer_abort_o, 1'h0, "abort on other request");
    wr(dcef_pkg::CONFIG_OFF, 32'h0000_0005);
    @(posedge clk_i);
    irq_valid_i <= 1'h1;
    @(posedge clk_i);
    irq_valid_i <= 1'h0;
    #1 chk(transfer_abort_o, 1'h0, "abort while disabled");
    rd(dcef_pkg::INT_CTRL_OFF);
    chk(d, 32'h0, "no abort flag");
    wr(dcef_pkg::CONFIG_OFF, 32'h8000_0005);
    $display("test abort miss done");
  endtask
  task automatic mid_reset();
    @(posedge clk_i);
    cell_done_i <= 1'h1;
    @(posedge clk_i);
    cell_done_i <= 1'h0;
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    rd(dcef_pkg::INT_CTRL_OFF);
    chk(d, 32'h0, "flags after reset");
    rd(dcef_pkg::CONFIG_OFF);
    chk(d, 32'h0, "config after reset");
    $display("test mid reset done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {sys_rst_i, wr_i, rd_i, addr_i, wdata_i} = {3'h4, 4'h0, 32'h0};
    {dest_pointer_i, dest_size_i, irq_num_i} = {16'h1, 16'h8, 8'h5};
    {block_done_i, pattern_match_i, cell_done_i, irq_valid_i} = 4'h0;
    {src_addr_bad_i, dst_addr_bad_i} = 2'h0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    wr(dcef_pkg::CONFIG_OFF, 32'h8000_0005);
    #1 chk(abort_request_select_o, 32'h5, "abort select");
    rd(dcef_pkg::CONFIG_OFF);
    chk(d, 32'h8000_0005, "config readback");
    rd(dcef_pkg::STATUS_OFF);
    chk(d, 32'h1, "pointer readback");
    for (int b = 0; b < 8; b++) hit(b);
    set_wins();
    abort_miss();
    mid_reset();
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc);
    chk(d, 32'h0, "unmapped read");
    rd(dcef_pkg::INT_CTRL_OFF);
    chk(d, 32'h0, "flags after unmapped write");
    $display("test registers done");
    close_out();
  end
  initial begin
    #(25 * 3000);
    miscompares++;
    close_out();
  end
endmodule
